// *** rtl/mic_pkg.sv ***
// Constants, register map and types shared by the interrupt control block
package mic_pkg;
	// Register word offsets (byte addresses on the Wishbone side)
	localparam logic [7:0] OFS_INTCTL = 8'h00;
	localparam logic [7:0] OFS_PEN1 = 8'h04;
	localparam logic [7:0] OFS_PEN2 = 8'h08;
	localparam logic [7:0] OFS_PREQ1 = 8'h0c;
	localparam logic [7:0] OFS_PREQ2 = 8'h10;
	localparam logic [7:0] OFS_EXTCFG = 8'h14;
	localparam logic [7:0] OFS_CORESTAT = 8'h18;
	// Shadow copies, the bank-31 window as seen from the bus
	localparam logic [7:0] OFS_SHD_ACC = 8'h20;
	localparam logic [7:0] OFS_SHD_STATUS = 8'h24;
	localparam logic [7:0] OFS_SHD_BANK = 8'h28;
	localparam logic [7:0] OFS_SHD_FSR0 = 8'h2c;
	localparam logic [7:0] OFS_SHD_FSR1 = 8'h30;
	localparam logic [7:0] OFS_SHD_PCLH = 8'h34;
	// interrupt_control fields
	localparam int B_GLOBAL_EN = 7;
	localparam int B_PERIPH_GATE = 6;
	localparam int B_T0IE = 5;
	localparam int B_EXTIE = 4;
	localparam int B_PCIE = 3;
	localparam int B_T0IF = 2;
	localparam int B_EXTIF = 1;
	localparam int B_PCIF = 0;
	// Peripheral enable / request fields
	localparam int B_ADC = 6;
	localparam int B_SER = 3;
	localparam int B_BCL = 3;
	// Status fields kept out of the shadow copy
	localparam int B_TIMEOUT = 4;
	localparam int B_POWERDOWN = 3;
	localparam logic [7:0] STATUS_SAVE_MASK = 8'he7;
	// Reset values
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic EXTCFG_RST = 1'b0;
	localparam logic [14:0] VECTOR_ADDR = 15'h0004;
	// Widths of saved core registers
	localparam int BANK_SEL_W = 5;
	localparam int PTR_W = 16;
	localparam int PCLH_W = 7;
	// Instruction cycle phases, one clock each
	localparam logic [1:0] PH_Q1 = 2'h0;
	localparam logic [1:0] PH_Q4 = 2'h3;
	// Instruction-cycle ends that the wake-up skip spans
	localparam logic [1:0] SKIP_Q4_COUNT = 2'h2;
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_SLEEP = 2'b01,
		ST_SKIP = 2'b10
	} mic_state_t;
endpackage

// *** rtl/mic_tick_if.sv ***
// Phase enables and external edge event passed between the block's modules
`timescale 1ns/100ps
`default_nettype none
interface mic_tick_if;
	logic q1;
	logic q4;
	logic ext_evt;
	modport phase (output q1, output q4);
	modport edge_det (output ext_evt);
	modport core (input q1, input q4, input ext_evt);
endinterface
`default_nettype wire

// *** rtl/mic_phase_gen.sv ***
// Instruction cycle phase divider: Q1 and Q4 enable pulses
`timescale 1ns/100ps
`default_nettype none
module mic_phase_gen
	import mic_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Phase enables
	mic_tick_if.phase tick
);
	logic [1:0] phase_r;
	logic q1_r;
	logic q4_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_r <= PH_Q1;
		end else begin
			phase_r <= phase_r + 2'h1;
		end
	end

	// Registered so the pulses line up with phase_r one cycle later
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q1_r <= 1'b0;
			q4_r <= 1'b0;
		end else begin
			q1_r <= (phase_r == PH_Q4);
			q4_r <= (phase_r == (PH_Q4 - 2'h1));
		end
	end

	assign tick.q1 = q1_r;
	assign tick.q4 = q4_r;
endmodule
`default_nettype wire

// *** rtl/mic_ext_edge.sv ***
// External interrupt pin synchroniser and selectable edge detector
`timescale 1ns/100ps
`default_nettype none
module mic_ext_edge (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Pin and edge choice
	input wire logic pin_i,
	input wire logic rising_i,
	// Edge event
	mic_tick_if.edge_det tick
);
	logic meta_r;
	logic sync_r;
	logic prev_r;
	logic rise;
	logic fall;

	// Pin is asynchronous; only sync_r is looked at downstream
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			meta_r <= pin_i;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign rise = sync_r & ~prev_r;
	assign fall = ~sync_r & prev_r;
	// Changing the selection while the pin is steady produces no event
	assign tick.ext_evt = rising_i ? rise : fall;
endmodule
`default_nettype wire

// *** rtl/mic_irq_top.sv ***
// Interrupt control: flags, enables, vectoring, wake-up and context shadows
`timescale 1ns/100ps
`default_nettype none
module mic_irq_top
	import mic_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Interrupt sources
	input wire logic ext_pin_i,
	input wire logic timer0_ovf_i,
	input wire logic adc_done_i,
	input wire logic serial_port_i,
	input wire logic bus_collision_i,
	input wire logic [5:0] pin_change_flag_bank_i,
	// Core sequencer
	input wire logic sleep_i,
	input wire logic return_from_isr_i,
	input wire logic [7:0] core_acc_i,
	input wire logic [7:0] core_status_i,
	input wire logic [BANK_SEL_W-1:0] core_bank_sel_i,
	input wire logic [PTR_W-1:0] core_fsr0_i,
	input wire logic [PTR_W-1:0] core_fsr1_i,
	input wire logic [PCLH_W-1:0] core_pclh_i,
	output logic vector_take_o,
	output logic [14:0] vector_addr_o,
	output logic restore_o,
	output logic wake_o,
	output logic q1_o,
	// Shadow copies toward the core
	output logic [7:0] shd_acc_o,
	output logic [7:0] shd_status_o,
	output logic [BANK_SEL_W-1:0] shd_bank_sel_o,
	output logic [PTR_W-1:0] shd_fsr0_o,
	output logic [PTR_W-1:0] shd_fsr1_o,
	output logic [PCLH_W-1:0] shd_pclh_o
);
	mic_tick_if tick ();

	mic_phase_gen u_phase (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick(tick)
	);

	logic ext_edge_select_r;

	mic_ext_edge u_edge (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(ext_pin_i),
		.rising_i(ext_edge_select_r),
		.tick(tick)
	);

	// Control and flag state
	logic global_irq_enable_r;
	logic peripheral_irq_gate_r;
	logic timer0_overflow_enable_r;
	logic external_irq_enable_r;
	logic pin_change_irq_enable_r;
	logic timer0_overflow_flag_r;
	logic external_irq_flag_r;
	logic pin_change_summary_flag_r;
	logic adc_done_enable_r;
	logic serial_port_irq_enable_r;
	logic bus_collision_enable_r;
	logic adc_done_flag_r;
	logic serial_port_irq_flag_r;
	logic bus_collision_flag_r;
	logic sampled_r;
	logic [1:0] skip_cnt_r;
	mic_state_t state_r;
	mic_state_t state_nxt;
	logic ack_r;
	logic [31:0] rdat_r;
	logic [31:0] rdat_nxt;

	// Bus decode
	logic acc;
	logic wr_lo;
	logic wr_hi;
	logic wr_intctl;
	logic wr_pen1;
	logic wr_pen2;
	logic wr_preq1;
	logic wr_preq2;
	logic wr_extcfg;
	logic wr_acc;
	logic wr_status;
	logic wr_bank;
	logic wr_fsr0_lo;
	logic wr_fsr0_hi;
	logic wr_fsr1_lo;
	logic wr_fsr1_hi;
	logic wr_pclh;

	assign acc = wb_cyc_i & wb_stb_i & ~ack_r;
	assign wr_lo = acc & wb_we_i & wb_sel_i[0];
	assign wr_hi = acc & wb_we_i & wb_sel_i[1];
	assign wr_intctl = wr_lo & (wb_adr_i == OFS_INTCTL);
	assign wr_pen1 = wr_lo & (wb_adr_i == OFS_PEN1);
	assign wr_pen2 = wr_lo & (wb_adr_i == OFS_PEN2);
	assign wr_preq1 = wr_lo & (wb_adr_i == OFS_PREQ1);
	assign wr_preq2 = wr_lo & (wb_adr_i == OFS_PREQ2);
	assign wr_extcfg = wr_lo & (wb_adr_i == OFS_EXTCFG);
	assign wr_acc = wr_lo & (wb_adr_i == OFS_SHD_ACC);
	assign wr_status = wr_lo & (wb_adr_i == OFS_SHD_STATUS);
	assign wr_bank = wr_lo & (wb_adr_i == OFS_SHD_BANK);
	assign wr_fsr0_lo = wr_lo & (wb_adr_i == OFS_SHD_FSR0);
	assign wr_fsr0_hi = wr_hi & (wb_adr_i == OFS_SHD_FSR0);
	assign wr_fsr1_lo = wr_lo & (wb_adr_i == OFS_SHD_FSR1);
	assign wr_fsr1_hi = wr_hi & (wb_adr_i == OFS_SHD_FSR1);
	assign wr_pclh = wr_lo & (wb_adr_i == OFS_SHD_PCLH);

	// Register images
	logic [7:0] intctl_img;
	logic [7:0] pen1_img;
	logic [7:0] pen2_img;
	logic [7:0] preq1_img;
	logic [7:0] preq2_img;

	assign intctl_img = {global_irq_enable_r, peripheral_irq_gate_r,
		timer0_overflow_enable_r, external_irq_enable_r,
		pin_change_irq_enable_r, timer0_overflow_flag_r,
		external_irq_flag_r, pin_change_summary_flag_r};
	assign pen1_img = REG_RST | (8'(adc_done_enable_r) << B_ADC) |
		(8'(serial_port_irq_enable_r) << B_SER);
	assign preq1_img = REG_RST | (8'(adc_done_flag_r) << B_ADC) |
		(8'(serial_port_irq_flag_r) << B_SER);
	assign pen2_img = REG_RST | (8'(bus_collision_enable_r) << B_BCL);
	assign preq2_img = REG_RST | (8'(bus_collision_flag_r) << B_BCL);

	// Interrupt qualification
	logic periph_any;
	logic enabled_any;
	logic irq_ready;
	logic take;

	assign periph_any = peripheral_irq_gate_r &
		((adc_done_enable_r & adc_done_flag_r) |
		(serial_port_irq_enable_r & serial_port_irq_flag_r) |
		(bus_collision_enable_r & bus_collision_flag_r));
	assign enabled_any = periph_any |
		(timer0_overflow_enable_r & timer0_overflow_flag_r) |
		(external_irq_enable_r & external_irq_flag_r) |
		(pin_change_irq_enable_r & pin_change_summary_flag_r);
	assign irq_ready = global_irq_enable_r & enabled_any;
	// Entry is paced by the phase counter, never by instruction length
	assign take = tick.q4 & sampled_r & irq_ready &
		(state_r == ST_RUN);

	// Enables and external edge selection
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			peripheral_irq_gate_r <= 1'b0;
			timer0_overflow_enable_r <= 1'b0;
			external_irq_enable_r <= 1'b0;
			pin_change_irq_enable_r <= 1'b0;
			adc_done_enable_r <= 1'b0;
			serial_port_irq_enable_r <= 1'b0;
			bus_collision_enable_r <= 1'b0;
			ext_edge_select_r <= EXTCFG_RST;
		end else begin
			if (wr_intctl) begin
				peripheral_irq_gate_r <= wb_dat_i[B_PERIPH_GATE];
				timer0_overflow_enable_r <= wb_dat_i[B_T0IE];
				external_irq_enable_r <= wb_dat_i[B_EXTIE];
				pin_change_irq_enable_r <= wb_dat_i[B_PCIE];
			end
			if (wr_pen1) begin
				adc_done_enable_r <= wb_dat_i[B_ADC];
				serial_port_irq_enable_r <= wb_dat_i[B_SER];
			end
			if (wr_pen2) begin
				bus_collision_enable_r <= wb_dat_i[B_BCL];
			end
			if (wr_extcfg) begin
				ext_edge_select_r <= wb_dat_i[0];
			end
		end
	end

	// Sticky flags: hardware set is ORed after the software write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer0_overflow_flag_r <= 1'b0;
			external_irq_flag_r <= 1'b0;
			adc_done_flag_r <= 1'b0;
			serial_port_irq_flag_r <= 1'b0;
			bus_collision_flag_r <= 1'b0;
			pin_change_summary_flag_r <= 1'b0;
		end else begin
			timer0_overflow_flag_r <= (wr_intctl ? wb_dat_i[B_T0IF] :
				timer0_overflow_flag_r) | timer0_ovf_i;
			external_irq_flag_r <= (wr_intctl ? wb_dat_i[B_EXTIF] :
				external_irq_flag_r) | tick.ext_evt;
			adc_done_flag_r <= (wr_preq1 ? wb_dat_i[B_ADC] :
				adc_done_flag_r) | adc_done_i;
			serial_port_irq_flag_r <= (wr_preq1 ? wb_dat_i[B_SER] :
				serial_port_irq_flag_r) | serial_port_i;
			bus_collision_flag_r <= (wr_preq2 ? wb_dat_i[B_BCL] :
				bus_collision_flag_r) | bus_collision_i;
			// Software cannot write it; follows the flag bank only
			pin_change_summary_flag_r <= |pin_change_flag_bank_i;
		end
	end

	// Global enable: entry clears, return sets, else software
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			global_irq_enable_r <= 1'b0;
		end else if (take) begin
			global_irq_enable_r <= 1'b0;
		end else if (return_from_isr_i) begin
			global_irq_enable_r <= 1'b1;
		end else if (wr_intctl) begin
			global_irq_enable_r <= wb_dat_i[B_GLOBAL_EN];
		end
	end

	// Once-per-cycle sample of the pending condition
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sampled_r <= 1'b0;
		end else if (take) begin
			sampled_r <= 1'b0;
		end else if (tick.q1) begin
			sampled_r <= irq_ready;
		end
	end

	// Sleep and wake sequencing
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_RUN: begin
				if (sleep_i) begin
					state_nxt = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				// Wake ignores global enable; only enabled sources count
				if (enabled_any) begin
					state_nxt = ST_SKIP;
				end
			end
			ST_SKIP: begin
				if (tick.q4 && skip_cnt_r == SKIP_Q4_COUNT) begin
					state_nxt = ST_RUN;
				end
			end
			default: begin
				state_nxt = ST_RUN;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= ST_RUN;
			skip_cnt_r <= 2'h0;
		end else begin
			state_r <= state_nxt;
			if (state_r != ST_SKIP) begin
				skip_cnt_r <= 2'h1;
			end else if (tick.q4) begin
				skip_cnt_r <= skip_cnt_r + 2'h1;
			end
		end
	end

	// Core strobes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vector_take_o <= 1'b0;
			restore_o <= 1'b0;
			wake_o <= 1'b0;
			q1_o <= 1'b0;
			vector_addr_o <= VECTOR_ADDR;
		end else begin
			vector_take_o <= take;
			restore_o <= return_from_isr_i;
			wake_o <= (state_r == ST_SLEEP) && (state_nxt == ST_SKIP);
			q1_o <= tick.q1;
			vector_addr_o <= VECTOR_ADDR;
		end
	end

	// Shadow copies: entry capture beats a software write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shd_acc_o <= REG_RST;
			shd_status_o <= REG_RST;
			shd_bank_sel_o <= '0;
			shd_pclh_o <= '0;
		end else if (take) begin
			shd_acc_o <= core_acc_i;
			shd_status_o <= core_status_i & STATUS_SAVE_MASK;
			shd_bank_sel_o <= core_bank_sel_i;
			shd_pclh_o <= core_pclh_i;
		end else begin
			if (wr_acc) shd_acc_o <= wb_dat_i[7:0];
			if (wr_status) shd_status_o <= wb_dat_i[7:0] & STATUS_SAVE_MASK;
			if (wr_bank) shd_bank_sel_o <= wb_dat_i[BANK_SEL_W-1:0];
			if (wr_pclh) shd_pclh_o <= wb_dat_i[PCLH_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shd_fsr0_o <= '0;
			shd_fsr1_o <= '0;
		end else if (take) begin
			shd_fsr0_o <= core_fsr0_i;
			shd_fsr1_o <= core_fsr1_i;
		end else begin
			if (wr_fsr0_lo) shd_fsr0_o[7:0] <= wb_dat_i[7:0];
			if (wr_fsr0_hi) shd_fsr0_o[15:8] <= wb_dat_i[15:8];
			if (wr_fsr1_lo) shd_fsr1_o[7:0] <= wb_dat_i[7:0];
			if (wr_fsr1_hi) shd_fsr1_o[15:8] <= wb_dat_i[15:8];
		end
	end

	// Read mux; unmapped addresses read zero and still acknowledge
	always_comb begin
		rdat_nxt = 32'h0000_0000;
		unique case (wb_adr_i)
			OFS_INTCTL: rdat_nxt[7:0] = intctl_img;
			OFS_PEN1: rdat_nxt[7:0] = pen1_img;
			OFS_PEN2: rdat_nxt[7:0] = pen2_img;
			OFS_PREQ1: rdat_nxt[7:0] = preq1_img;
			OFS_PREQ2: rdat_nxt[7:0] = preq2_img;
			OFS_EXTCFG: rdat_nxt[0] = ext_edge_select_r;
			OFS_CORESTAT: rdat_nxt[1:0] = state_r;
			OFS_SHD_ACC: rdat_nxt[7:0] = shd_acc_o;
			OFS_SHD_STATUS: rdat_nxt[7:0] = shd_status_o;
			OFS_SHD_BANK: rdat_nxt[BANK_SEL_W-1:0] = shd_bank_sel_o;
			OFS_SHD_FSR0: rdat_nxt[PTR_W-1:0] = shd_fsr0_o;
			OFS_SHD_FSR1: rdat_nxt[PTR_W-1:0] = shd_fsr1_o;
			OFS_SHD_PCLH: rdat_nxt[PCLH_W-1:0] = shd_pclh_o;
			default: rdat_nxt = 32'h0000_0000;
		endcase
	end

	// Answer one cycle after the request; ack lasts a single cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			rdat_r <= 32'h0000_0000;
		end else begin
			ack_r <= acc;
			if (acc) begin
				rdat_r <= rdat_nxt;
			end
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;
endmodule
`default_nettype wire

// *** testbench/mic_irq_top_asserts.sv ***
// Port-level checker for the interrupt control block
`timescale 1ns/100ps
`default_nettype none
module mic_irq_top_asserts
	import mic_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Register bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Core side
	input wire logic sleep_i,
	input wire logic return_from_isr_i,
	input wire logic [7:0] core_acc_i,
	input wire logic [7:0] core_status_i,
	input wire logic [PCLH_W-1:0] core_pclh_i,
	input wire logic vector_take_o,
	input wire logic [14:0] vector_addr_o,
	input wire logic restore_o,
	input wire logic wake_o,
	input wire logic q1_o,
	input wire logic [7:0] shd_acc_o,
	input wire logic [7:0] shd_status_o,
	input wire logic [PCLH_W-1:0] shd_pclh_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_answer: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered in one cycle");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_upper_zero: assert property (
		wb_ack_o && !wb_we_i && wb_adr_i < 8'h2c |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_vector_fixed: assert property (vector_addr_o == VECTOR_ADDR)
		else $error("vector address wrong");
	a_q1_period: assert property (q1_o |=> !q1_o [*3] ##1 q1_o)
		else $error("sample phase not every fourth clock");
	a_take_once: assert property (vector_take_o |=> !vector_take_o [*8])
		else $error("second take while global enable cleared");
	a_shadow_take: assert property (
		vector_take_o |-> shd_acc_o == $past(core_acc_i)
		&& shd_pclh_o == $past(core_pclh_i))
		else $error("context not captured on take");
	a_status_mask: assert property (
		vector_take_o |-> shd_status_o == ($past(core_status_i) & 8'he7))
		else $error("status shadow wrong");
	a_restore_ret: assert property (return_from_isr_i |-> ##[1:2] restore_o)
		else $error("no restore after return");
	a_wake_asleep: assert property (wake_o |-> $past(sleep_i))
		else $error("wake while not asleep");
	a_skip_first: assert property ($rose(wake_o) |-> !vector_take_o [*4])
		else $error("take before instruction after sleep");
endmodule
bind mic_irq_top mic_irq_top_asserts chk_u (.clk_i, .rst_i, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .sleep_i,
	.return_from_isr_i, .core_acc_i, .core_status_i, .core_pclh_i,
	.vector_take_o, .vector_addr_o, .restore_o, .wake_o, .q1_o, .shd_acc_o,
	.shd_status_o, .shd_pclh_o);
`default_nettype wire

// *** testbench/mic_core_model.sv ***
// Stand-in for the core sequencer on the far side of the interrupt block
`timescale 1ns/100ps
`default_nettype none
module mic_core_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bench requests
	input wire logic sleep_req_i,
	input wire logic ret_req_i,
	// From the interrupt block
	input wire logic restore_i,
	input wire logic wake_i,
	input wire logic [7:0] shd_acc_i,
	input wire logic [7:0] shd_status_i,
	// Toward the interrupt block
	output logic sleep_o,
	output logic ret_o,
	output logic [7:0] acc_o,
	output logic [7:0] status_o
);
	// Own timeout and power-down bits survive the reload
	logic [7:0] status_nxt;
	assign status_nxt = {shd_status_i[7:5], status_o[4:3], shd_status_i[2:0]};
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sleep_o <= 1'b0;
			ret_o <= 1'b0;
			acc_o <= 8'h00;
			status_o <= 8'h1f;
		end else begin
			ret_o <= ret_req_i;
			if (sleep_req_i) begin
				sleep_o <= 1'b1;
			end else if (wake_i) begin
				sleep_o <= 1'b0;
			end
			if (restore_i) begin
				acc_o <= shd_acc_i;
				status_o <= status_nxt;
			end else begin
				// Context keeps moving so a stale capture shows up
				acc_o <= acc_o + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// *** testbench/test_mic_irq_top.sv ***
// Self-checking bench for the interrupt control block
`timescale 1ns/100ps
`default_nettype none
module test_mic_irq_top;
	import mic_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [31:0] wb_wdat = 32'h0;
	logic [31:0] wb_rdat, rd;
	logic wb_ack, ext_pin = 1'b1, sleep_req = 1'b0, ret_req = 1'b0;
	logic [3:0] src = 4'h0;
	logic [5:0] pc_bank = 6'h00;
	logic sleep_w, ret_w, take_w, rest_w, wake_w;
	logic [7:0] acc_w, stat_w, sacc_w, sstat_w;
	int failures = 0;
	int tests_run = 0;
	int n;
	always #5 clk_i = ~clk_i;
	mic_core_model core_u (.clk_i(clk_i), .rst_i(rst_i),
		.sleep_req_i(sleep_req), .ret_req_i(ret_req), .restore_i(rest_w),
		.wake_i(wake_w), .shd_acc_i(sacc_w), .shd_status_i(sstat_w),
		.sleep_o(sleep_w), .ret_o(ret_w), .acc_o(acc_w), .status_o(stat_w));
	mic_irq_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(4'h3), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
		.wb_ack_o(wb_ack), .ext_pin_i(ext_pin), .timer0_ovf_i(src[0]),
		.adc_done_i(src[1]), .serial_port_i(src[2]),
		.bus_collision_i(src[3]), .pin_change_flag_bank_i(pc_bank),
		.sleep_i(sleep_w), .return_from_isr_i(ret_w), .core_acc_i(acc_w),
		.core_status_i(stat_w), .core_bank_sel_i(acc_w[4:0]),
		.core_fsr0_i({acc_w, ~acc_w}), .core_fsr1_i({~acc_w, acc_w}),
		.core_pclh_i(acc_w[6:0]), .vector_take_o(take_w),
		.vector_addr_o(), .restore_o(rest_w), .wake_o(wake_w), .q1_o(),
		.shd_acc_o(sacc_w), .shd_status_o(sstat_w), .shd_bank_sel_o(),
		.shd_fsr0_o(), .shd_fsr1_o(), .shd_pclh_o());
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic bus(input logic we, input logic [7:0] a, input int d);
		int k = 0;
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_wdat <= d;
		// Ack is sampled on the rising edge; read data is taken there too
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack !== 1'b1 && k < 20);
		rd = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		if (k >= 20) begin
			failures++;
			$display("mismatch bus ack expected 1 seen 0");
			conclude();
		end
	endtask
	task automatic wr(input logic [7:0] a, input int d);
		bus(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input int e, input string nm);
		bus(1'b0, a, 0);
		chk(nm, rd, e);
	endtask
	function automatic logic pick(input int k);
		return k == 0 ? take_w : (k == 1 ? wake_w : rest_w);
	endfunction
	task automatic wait_on(input int k, input int lim);
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (pick(k) !== 1'b1 && n < lim);
		if (pick(k) !== 1'b1) begin
			failures++;
			$display("mismatch event %0d expected 1 seen 0", k);
			conclude();
		end
	endtask
	task automatic quiet(input int len);
		logic seen = 1'b0;
		repeat (len) begin
			@(negedge clk_i);
			seen = seen | take_w;
		end
		chk("no take", {31'h0, seen}, 32'h0);
	endtask
	task automatic pulse(input logic [3:0] v);
		@(posedge clk_i);
		src <= v;
		@(posedge clk_i);
		src <= 4'h0;
	endtask
	task automatic pin(input logic v);
		@(posedge clk_i);
		ext_pin <= v;
		repeat (6) @(posedge clk_i);
	endtask
	task automatic zero_check();
		for (int a = 0; a < 8'h18; a += 4) begin
			rdc(a[7:0], 32'h0, "reset value");
		end
		rdc(8'h3c, 32'h0, "unmapped");
	endtask
	logic [7:0] adrs [4] = '{OFS_PEN1, OFS_PEN2, OFS_PREQ1, OFS_PREQ2};
	logic [7:0] masks [4] = '{8'h48, 8'h08, 8'h48, 8'h08};
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		zero_check();
		for (int i = 0; i < 4; i++) begin
			wr(adrs[i], 32'hff);
			rdc(adrs[i], {24'h0, masks[i]}, "masked reg");
			wr(adrs[i], 32'h0);
		end
		wr(OFS_INTCTL, 32'h7f);
		rdc(OFS_INTCTL, 32'h7e, "control bits");
		wr(OFS_INTCTL, 32'h0);
		$display("register test done");
		pulse(4'hf);
		quiet(12);
		rdc(OFS_INTCTL, 32'h04, "flags");
		rdc(OFS_PREQ1, 32'h48, "flags one");
		rdc(OFS_PREQ2, 32'h08, "flags two");
		wr(OFS_PREQ1, 32'h0);
		wr(OFS_PREQ2, 32'h0);
		fork
			wr(OFS_INTCTL, 32'h0);
			pulse(4'h1);
		join
		rdc(OFS_INTCTL, 32'h04, "set beats clear");
		wr(OFS_INTCTL, 32'h0);
		@(posedge clk_i);
		pc_bank <= 6'h05;
		rdc(OFS_INTCTL, 32'h01, "pin change");
		wr(OFS_INTCTL, 32'h0);
		rdc(OFS_INTCTL, 32'h01, "summary held");
		pc_bank <= 6'h00;
		rdc(OFS_INTCTL, 32'h0, "summary clear");
		$display("flag test done");
		pin(1'b0);
		rdc(OFS_INTCTL, 32'h02, "falling edge");
		wr(OFS_INTCTL, 32'h0);
		pin(1'b1);
		rdc(OFS_INTCTL, 32'h0, "rising ignored");
		wr(OFS_EXTCFG, 32'h1);
		pin(1'b0);
		rdc(OFS_INTCTL, 32'h0, "falling ignored");
		pin(1'b1);
		rdc(OFS_INTCTL, 32'h02, "rising edge");
		wr(OFS_EXTCFG, 32'h0);
		wr(OFS_INTCTL, 32'h90);
		@(posedge clk_i);
		ext_pin <= 1'b0;
		wait_on(0, 14);
		wr(OFS_INTCTL, 32'h20);
		pulse(4'h1);
		quiet(12);
		wr(OFS_INTCTL, 32'ha4);
		wait_on(0, 10);
		rdc(OFS_INTCTL, 32'h24, "take clears enable");
		rdc(OFS_SHD_STATUS, 32'h07, "status shadow");
		wr(OFS_SHD_ACC, 32'h5a);
		wr(OFS_SHD_FSR0, 32'ha55a);
		rdc(OFS_SHD_FSR0, 32'ha55a, "pointer shadow");
		wr(OFS_INTCTL, 32'h20);
		@(posedge clk_i);
		ret_req <= 1'b1;
		@(posedge clk_i);
		ret_req <= 1'b0;
		wait_on(2, 4);
		@(negedge clk_i);
		chk("restored acc", {24'h0, acc_w}, 32'h5a);
		chk("restored status", {24'h0, stat_w}, 32'h1f);
		rdc(OFS_INTCTL, 32'ha0, "return enables");
		wr(OFS_PEN1, 32'h40);
		wr(OFS_INTCTL, 32'h80);
		pulse(4'h2);
		quiet(16);
		wr(OFS_INTCTL, 32'hc0);
		wait_on(0, 10);
		wr(OFS_PREQ1, 32'h0);
		$display("vector test done");
		wr(OFS_PEN2, 32'h08);
		wr(OFS_INTCTL, 32'h40);
		for (int g = 0; g < 2; g++) begin
			@(posedge clk_i);
			sleep_req <= 1'b1;
			@(posedge clk_i);
			sleep_req <= 1'b0;
			pulse(4'h8);
			wait_on(1, 6);
			if (g == 0) begin
				quiet(16);
			end else begin
				wait_on(0, 16);
				chk("skip span", {31'h0, n > 4}, 32'h1);
			end
			wr(OFS_PREQ2, 32'h0);
			wr(OFS_INTCTL, 32'hc0);
		end
		$display("sleep test done");
		wr(OFS_PEN1, 32'h48);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		zero_check();
		$display("reset test done");
		conclude();
	end
endmodule
`default_nettype wire
